// ==== logic/tpsd_consts.vh ====
// constants and register map of the transmit pulse shaper and driver control
// Operation
// [R1] j1 template defaults scale 110110, 2% step
// [R2] ds1 -7.5 dB template scale 010001, 6.25%
// [R3] ds1 -22.5 dB template scale 000100, 25%
// [R4] templates: 7-bit samples, 16 per ui, 4 ui
// [R5] overlapping pulses overflowing amplitude latch status
// [R6] overflow interrupt needs status and enable
// [R7] global tristate pin floats every driver
// [R8] stuck or badly skewed oscillator floats drivers
// [R9] drivers float after any reset
// [R10] per-link tristate bit floats that driver
// [R11] master mode recovered clock loss floats driver
// [R12] slave mode backplane clock loss floats driver
// [R13] remote loopback suppresses backplane loss tristate
// [R14] transmit power down floats that driver
// [R15] tristate conditions act without boundary wait
// [R16] driver monitor reports overcurrent as failure state
// [R17] failure status set on rise or both edges
// [R18] failure interrupt needs status and enable
// [R19] software triggers each template sample transfer
// [R20] scaling only applies to user templates
// [R21] interrupt active low, status sticky until cleared
// [R22] four link copies, 0x100 index apart
`ifndef TPSD_CONSTS_VH
`define TPSD_CONSTS_VH

// register indices; byte address is four times the index
`define TPSD_IDX_PSEL 8'h23
`define TPSD_IDX_SCALE 8'h24
`define TPSD_IDX_RAMCTL 8'h25
`define TPSD_IDX_RAMDAT 8'h26
`define TPSD_IDX_IEN0 8'h33
`define TPSD_IDX_IEN1 8'h34
`define TPSD_IDX_EDGE 8'h35
`define TPSD_IDX_LSTAT 8'h36
`define TPSD_IDX_IST0 8'h3A
`define TPSD_IDX_IST1 8'h3B
`define TPSD_IDX_TIMING 8'h70

// field positions
`define TPSD_PSEL_HIZ 4
`define TPSD_PSEL_DMON 5
`define TPSD_CTL_RW 6
`define TPSD_CTL_DONE 7
`define TPSD_TIM_XTS 0
`define TPSD_TIM_MASTER 1
`define TPSD_TIM_RLB 2
`define TPSD_TIM_PD 3

// template codes
`define TPSD_TPL_T1_0_133 4'h2
`define TPSD_TPL_J1 4'h7
`define TPSD_TPL_DS1_0DB 4'h8
`define TPSD_TPL_DS1_7P5 4'h9
`define TPSD_TPL_DS1_22P5 4'hB
`define TPSD_TPL_USER 4'hC

// standard scale codes
`define TPSD_SCALE_J1 6'h36
`define TPSD_SCALE_DS1_7P5 6'h11
`define TPSD_SCALE_DS1_22P5 6'h04

// reset values
`define TPSD_RST_PSEL 8'h17
`define TPSD_RST_TIMING 4'h0

// timing
`define TPSD_PCLK_NS 8
`define TPSD_OSC_STUCK_NS 2000
`define TPSD_LINE_PERIOD_NS 648
`define TPSD_BP_LOSS_LINE_CYCLES 72
`define TPSD_OSC_DUTY_LO 30
`define TPSD_OSC_DUTY_HI 70

`endif

// ==== logic/tpsd_top.v ====
// transmit pulse shaper and line driver control for four links, apb slave
`timescale 1ns/100ps
`include "tpsd_consts.vh"

module tpsd_top #(
    parameter BP_LOSS_CYCLES = `TPSD_BP_LOSS_LINE_CYCLES *
        `TPSD_LINE_PERIOD_NS / `TPSD_PCLK_NS
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // pins
    input wire global_tristate_pin,
    input wire reference_osc_in,
    output reg irq_n,
    // per-link line side
    input wire [3:0] tx_sample_tick,
    input wire [3:0] tx_mark,
    input wire [3:0] tx_mark_neg,
    input wire [3:0] rclk_lost,
    input wire [3:0] bp_clk,
    input wire [3:0] driver_overcurrent,
    output reg [27:0] dac_code,
    output reg [3:0] tx_line_oe
);

localparam OSC_STUCK_CYC = `TPSD_OSC_STUCK_NS / `TPSD_PCLK_NS;
localparam [12:0] BP_LOSS = BP_LOSS_CYCLES;
localparam [15:0] OSC_STUCK = OSC_STUCK_CYC;

// apb decode
wire acc = psel & penable & pready;
wire wr = acc & pwrite;
wire rd = acc & ~pwrite;
// [R22] link from address
wire [1:0] lnk = paddr[11:10];
wire [7:0] loc = paddr[9:2];
wire [7:0] wd = pwdata[7:0];

// per-link register state, flattened
reg [31:0] psel_reg;
reg [23:0] scale_reg;
reg [23:0] ramctl_reg;
reg [27:0] ramdat_reg;
reg [15:0] tim_reg;
reg [3:0] ovf_en;
reg [3:0] ovf_st;
reg [3:0] df_en;
reg [3:0] df_es;
reg [3:0] df_state;
reg [3:0] df_st;
reg [3:0] next_hiz;

// template memory: link, ui, sample
reg [6:0] tpl_ram [0:255];

// preset j1 / ds1 0 dB / t1 0-133 ft samples
function [6:0] j1_sample;
    input [5:0] pos;
    begin
        case (pos)
            6'h00: j1_sample = 7'h17;
            6'h01: j1_sample = 7'h27;
            6'h02: j1_sample = 7'h27;
            6'h03: j1_sample = 7'h26;
            6'h04: j1_sample = 7'h25;
            6'h05: j1_sample = 7'h25;
            6'h06: j1_sample = 7'h25;
            6'h07: j1_sample = 7'h24;
            6'h08: j1_sample = 7'h23;
            6'h09: j1_sample = 7'h4A;
            6'h0A: j1_sample = 7'h4A;
            6'h0B: j1_sample = 7'h49;
            6'h0C: j1_sample = 7'h47;
            6'h0D: j1_sample = 7'h45;
            6'h0E: j1_sample = 7'h44;
            6'h0F: j1_sample = 7'h43;
            6'h10: j1_sample = 7'h42;
            6'h11: j1_sample = 7'h41;
            default: j1_sample = 7'h00;
        endcase
    end
endfunction

// standard scale code of a template
function [5:0] std_scale;
    input [3:0] tpl;
    begin
        case (tpl)
            `TPSD_TPL_DS1_7P5: std_scale = `TPSD_SCALE_DS1_7P5;
            // [R3] ds1 -22.5 code
            `TPSD_TPL_DS1_22P5: std_scale = `TPSD_SCALE_DS1_22P5;
            default: std_scale = `TPSD_SCALE_J1;
        endcase
    end
endfunction

// address map check
reg hit;
reg [7:0] rd_val;
always @* begin
    hit = 1'b1;
    rd_val = 8'h00;
    case (loc)
        `TPSD_IDX_PSEL: rd_val = psel_reg[8*lnk+:8];
        `TPSD_IDX_SCALE: rd_val = {2'b00, scale_reg[6*lnk+:6]};
        `TPSD_IDX_RAMCTL: rd_val = {2'b00, ramctl_reg[6*lnk+:6]};
        `TPSD_IDX_RAMDAT: rd_val = {1'b0, ramdat_reg[7*lnk+:7]};
        `TPSD_IDX_IEN0: rd_val = {7'h00, df_en[lnk]};
        `TPSD_IDX_IEN1: rd_val = {7'h00, ovf_en[lnk]};
        `TPSD_IDX_EDGE: rd_val = {7'h00, df_es[lnk]};
        `TPSD_IDX_LSTAT: rd_val = {7'h00, df_state[lnk]};
        `TPSD_IDX_IST0: rd_val = {7'h00, df_st[lnk]};
        `TPSD_IDX_IST1: rd_val = {7'h00, ovf_st[lnk]};
        `TPSD_IDX_TIMING: rd_val = {4'h0, tim_reg[4*lnk+:4]};
        default: hit = 1'b0;
    endcase
    if (paddr[31:12] != 20'h00000 || paddr[1:0] != 2'b00) begin
        hit = 1'b0;
        rd_val = 8'h00;
    end
end

// apb response: data captured in setup, answered in first access cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= psel & ~penable;
        pslverr <= psel & ~penable & ~hit;
        if (psel & ~penable)
            prdata <= {24'h000000, rd_val};
    end
end

// software-triggered template memory write
always @(posedge pclk) begin
    // [R19] trigger moves one sample
    if (wr && hit && loc == `TPSD_IDX_RAMCTL && wd[`TPSD_CTL_DONE] &&
            !wd[`TPSD_CTL_RW])
        tpl_ram[{lnk, wd[5:0]}] <= ramdat_reg[7*lnk+:7];
end

// reference oscillator monitor
reg ref_prev;
reg [15:0] osc_period;
reg [15:0] osc_high;
reg osc_duty_bad;
reg osc_bad;
wire ref_rise = reference_osc_in & ~ref_prev;
wire [19:0] high_x100 = {4'h0, osc_high} * 20'd100;
wire [22:0] per_lo = {7'h00, osc_period} * 23'd`TPSD_OSC_DUTY_LO;
wire [22:0] per_hi = {7'h00, osc_period} * 23'd`TPSD_OSC_DUTY_HI;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ref_prev <= 1'b0;
        // saturated so the first partial period reads as bad
        osc_period <= 16'hFFFF;
        osc_high <= 16'h0000;
        osc_duty_bad <= 1'b1;
        osc_bad <= 1'b1;
    end else begin
        ref_prev <= reference_osc_in;
        if (ref_rise) begin
            // [R8] duty outside bounds
            osc_duty_bad <= ({3'b000, high_x100} < per_lo) ||
                ({3'b000, high_x100} > per_hi);
            osc_period <= 16'h0001;
            osc_high <= 16'h0001;
        end else begin
            if (osc_period != 16'hFFFF)
                osc_period <= osc_period + 16'h0001;
            if (reference_osc_in && osc_high != 16'hFFFF)
                osc_high <= osc_high + 16'h0001;
        end
        // [R8] stuck level or bad duty
        osc_bad <= osc_duty_bad || (osc_period >= OSC_STUCK);
    end
end

// per-link logic
genvar l;
generate
    for (l = 0; l < 4; l = l + 1) begin : g_link
        localparam [1:0] LID = l;
        wire sel = (lnk == LID) & hit;
        wire wsel = wr & sel;
        wire [3:0] tpl = psel_reg[8*l+:4];
        wire [3:0] tim = tim_reg[4*l+:4];
        reg [3:0] samp_pos;
        reg [3:0] hist_mark;
        reg [3:0] hist_neg;
        reg bp_prev;
        reg [12:0] bp_cnt;
        reg df_prev;
        reg [9:0] sum;
        reg [9:0] mag;
        reg [15:0] scaled;
        reg [6:0] v;
        reg ovf;
        integer k;

        // configuration and status registers
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                // [R9] link tristate set at reset
                psel_reg[8*l+:8] <= `TPSD_RST_PSEL;
                // [R1] j1 standard scale default
                scale_reg[6*l+:6] <= `TPSD_SCALE_J1;
                ramctl_reg[6*l+:6] <= 6'h00;
                ramdat_reg[7*l+:7] <= 7'h00;
                tim_reg[4*l+:4] <= `TPSD_RST_TIMING;
                ovf_en[l] <= 1'b0;
                df_en[l] <= 1'b0;
                df_es[l] <= 1'b0;
            end else begin
                if (wsel && loc == `TPSD_IDX_PSEL) begin
                    psel_reg[8*l+:8] <= wd;
                    // [R2] standard scale follows template
                    if (wd[3:0] != tpl)
                        scale_reg[6*l+:6] <= std_scale(wd[3:0]);
                end
                if (wsel && loc == `TPSD_IDX_SCALE)
                    scale_reg[6*l+:6] <= wd[5:0];
                if (wsel && loc == `TPSD_IDX_RAMCTL)
                    ramctl_reg[6*l+:6] <= wd[5:0];
                if (wsel && loc == `TPSD_IDX_RAMDAT)
                    ramdat_reg[7*l+:7] <= wd[6:0];
                // [R19] read trigger fetches one sample
                if (wsel && loc == `TPSD_IDX_RAMCTL &&
                        wd[`TPSD_CTL_DONE] && wd[`TPSD_CTL_RW])
                    ramdat_reg[7*l+:7] <= tpl_ram[{LID, wd[5:0]}];
                if (wsel && loc == `TPSD_IDX_IEN0)
                    df_en[l] <= wd[0];
                if (wsel && loc == `TPSD_IDX_IEN1)
                    ovf_en[l] <= wd[0];
                if (wsel && loc == `TPSD_IDX_EDGE)
                    df_es[l] <= wd[0];
                if (wsel && loc == `TPSD_IDX_TIMING)
                    tim_reg[4*l+:4] <= wd[3:0];
            end
        end

        // sum of overlapping pulses at this sample position
        always @* begin
            sum = 10'h000;
            mag = 10'h000;
            scaled = 16'h0000;
            v = 7'h00;
            for (k = 0; k < 4; k = k + 1) begin
                // [R4] 16 samples per ui over four ui
                if (tpl == `TPSD_TPL_J1 || tpl == `TPSD_TPL_DS1_0DB ||
                        tpl == `TPSD_TPL_T1_0_133)
                    v = j1_sample({k[1:0], samp_pos});
                else
                    v = tpl_ram[{LID, k[1:0], samp_pos}];
                if (hist_mark[k]) begin
                    if (v[6] ^ hist_neg[k])
                        sum = sum - {4'h0, v[5:0]};
                    else
                        sum = sum + {4'h0, v[5:0]};
                end
            end
            mag = sum[9] ? (10'h000 - sum) : sum;
            // [R20] scale only user templates
            if (tpl >= `TPSD_TPL_USER)
                scaled = ({6'h00, mag} * {10'h000, scale_reg[6*l+:6]}) >> 5;
            else
                scaled = {6'h00, mag};
            ovf = (scaled > 16'h003F);
        end

        // playout, overflow and interrupt status
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                samp_pos <= 4'h0;
                hist_mark <= 4'h0;
                hist_neg <= 4'h0;
                dac_code[7*l+:7] <= 7'h00;
                ovf_st[l] <= 1'b0;
                df_state[l] <= 1'b0;
                df_prev <= 1'b0;
                df_st[l] <= 1'b0;
            end else begin
                if (tx_sample_tick[l]) begin
                    samp_pos <= samp_pos + 4'h1;
                    if (samp_pos == 4'hF) begin
                        hist_mark <= {hist_mark[2:0], tx_mark[l]};
                        hist_neg <= {hist_neg[2:0], tx_mark_neg[l]};
                    end
                    dac_code[7*l+:7] <= {sum[9],
                        ovf ? 6'h3F : scaled[5:0]};
                end
                // [R5] overflow latched, [R21] set wins
                ovf_st[l] <= (ovf_st[l] & ~(rd && sel &&
                    loc == `TPSD_IDX_IST1 && prdata[0])) |
                    (tx_sample_tick[l] & ovf);
                // [R16] monitor gates failure state
                df_state[l] <= tim[`TPSD_TIM_PD] ? 1'b0 :
                    driver_overcurrent[l] & psel_reg[8*l+`TPSD_PSEL_DMON];
                df_prev <= df_state[l];
                // [R17] rise or either edge
                df_st[l] <= (df_st[l] & ~(rd && sel &&
                    loc == `TPSD_IDX_IST0 && prdata[0])) |
                    ((df_state[l] & ~df_prev) |
                    (df_es[l] & ~df_state[l] & df_prev));
            end
        end

        // backplane clock activity
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                bp_prev <= 1'b0;
                bp_cnt <= 13'h0000;
            end else begin
                bp_prev <= bp_clk[l];
                if (bp_clk[l] != bp_prev)
                    bp_cnt <= 13'h0000;
                else if (bp_cnt != BP_LOSS)
                    bp_cnt <= bp_cnt + 13'h0001;
            end
        end

        // driver tristate conditions
        always @* begin
            next_hiz[l] = 1'b0;
            // [R7] global pin
            if (global_tristate_pin)
                next_hiz[l] = 1'b1;
            // [R8] oscillator failure
            if (osc_bad)
                next_hiz[l] = 1'b1;
            // [R10] per-link bit
            if (psel_reg[8*l+`TPSD_PSEL_HIZ])
                next_hiz[l] = 1'b1;
            // [R11] recovered clock lost
            if (tim[`TPSD_TIM_MASTER] && tim[`TPSD_TIM_XTS] && rclk_lost[l])
                next_hiz[l] = 1'b1;
            // [R12] backplane lost, [R13] loopback exempt
            if (!tim[`TPSD_TIM_MASTER] && !tim[`TPSD_TIM_XTS] &&
                    bp_cnt == BP_LOSS && !tim[`TPSD_TIM_RLB])
                next_hiz[l] = 1'b1;
            // [R14] power down
            if (tim[`TPSD_TIM_PD])
                next_hiz[l] = 1'b1;
        end
    end
endgenerate

// output enables and interrupt
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        // [R9] drivers float in reset
        tx_line_oe <= 4'h0;
        irq_n <= 1'b1;
    end else begin
        // [R15] next cycle, no boundary wait
        tx_line_oe <= ~next_hiz;
        // [R6] [R18] [R21] enabled status drives low
        irq_n <= ~(|((ovf_st & ovf_en) | (df_st & df_en)));
    end
end

endmodule // tpsd_top

// ==== bench/tpsd_top_chk.sv ====
// assertion checker for the transmit pulse shaper and driver control
`timescale 1ns/100ps
module tpsd_top_chk #(
    parameter BP_LOSS_CYCLES = 20
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire [31:0] paddr,
    input wire pready,
    input wire pslverr,
    // pins and line side
    input wire global_tristate_pin,
    input wire reference_osc_in,
    input wire irq_n,
    input wire [3:0] tx_sample_tick,
    input wire [27:0] dac_code,
    input wire [3:0] tx_line_oe
);
    reg [9:0] osc_still;
    reg osc_last;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // cycles since the oscillator input last moved
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_still <= 10'h000;
            osc_last <= 1'h0;
        end else begin
            osc_last <= reference_osc_in;
            if (reference_osc_in != osc_last)
                osc_still <= 10'h000;
            else if (osc_still != 10'h3FF)
                osc_still <= osc_still + 10'h001;
        end
    end

    property p_glob_hiz;
        global_tristate_pin |=> tx_line_oe == 4'h0;
    endproperty
    a_glob_hiz: assert property (p_glob_hiz) else $error("driver on in global tristate");
    property p_osc_stuck;
        osc_still > 10'h104 |-> tx_line_oe == 4'h0;
    endproperty
    a_osc_stuck: assert property (p_osc_stuck) else $error("driver on, osc stuck");
    property p_reset_hiz;
        $rose(presetn) |-> (tx_line_oe == 4'h0) [*8];
    endproperty
    a_reset_hiz: assert property (p_reset_hiz) else $error("driver on after reset");
    property p_reset_irq;
        $rose(presetn) |-> irq_n;
    endproperty
    a_reset_irq: assert property (p_reset_irq) else $error("irq active after reset");
    property p_irq_clear;
        $rose(irq_n) |-> $past(psel && penable) || $past(psel && penable, 2)
            || $past(psel && penable, 3);
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq dropped by itself");
    property p_misalign;
        psel && !penable && paddr[1:0] != 2'h0 |=> pready && pslverr;
    endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned not refused");
    property p_high_addr;
        psel && !penable && paddr[31:12] != 20'h0 |=> pready && pslverr;
    endproperty
    a_high_addr: assert property (p_high_addr) else $error("high address accepted");
    property p_dac_tick;
        $changed(dac_code) |-> $past(tx_sample_tick != 4'h0);
    endproperty
    a_dac_tick: assert property (p_dac_tick) else $error("dac moved off tick");
endmodule // tpsd_top_chk

bind tpsd_top tpsd_top_chk #(.BP_LOSS_CYCLES(BP_LOSS_CYCLES)) u_chk (.*);

// ==== bench/tpsd_top_tb.sv ====
// self-checking bench for the transmit pulse shaper and driver control
`timescale 1ns/100ps
`include "tpsd_consts.vh"
module tpsd_top_tb;
    reg pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    reg pwrite = 1'h0, global_tristate_pin = 1'h0, reference_osc_in = 1'h0;
    reg [31:0] paddr = 32'h0, pwdata = 32'h0, r;
    reg [3:0] tx_sample_tick = 4'h0, tx_mark = 4'h0, tx_mark_neg = 4'h0;
    reg [3:0] rclk_lost = 4'h0, bp_clk = 4'h0, driver_overcurrent = 4'h0;
    reg [3:0] bp_run = 4'hF;
    reg look_go = 1'h0, osc_run = 1'h1, force0 = 1'h0;
    reg [1:0] look_sel = 2'h0;
    reg [7:0] tpl [0:2] = '{`TPSD_TPL_J1, `TPSD_TPL_DS1_7P5, `TPSD_TPL_DS1_22P5};
    reg [31:0] scl [0:2] = '{32'h36, 32'h11, 32'h04};
    wire [31:0] prdata;
    wire pready, pslverr, irq_n;
    wire [27:0] dac_code;
    wire [3:0] tx_line_oe;
    reg [31:0] expq[$];
    integer miscompares = 0, samples_checked = 0, seed = 67;
    integer oc = 0, hi = 4, tc = 0, l, k;

    tpsd_top #(.BP_LOSS_CYCLES(20)) DUT (.*);

    always #4 pclk = ~pclk;

    // ticks, random marks, oscillator and backplane clocks
    always @(posedge pclk) begin
        r = $random(seed);
        tc <= (tc + 1) % 4;
        tx_sample_tick <= {4{tc == 0}};
        oc <= (oc + 1) % 8;
        reference_osc_in <= osc_run && oc < hi;
        if (tc == 0) begin
            bp_clk <= bp_clk ^ bp_run;
            tx_mark <= (r[3:0] & 4'hE) | {3'h0, force0};
            tx_mark_neg <= r[7:4] & ~r[3:0] & 4'hE;
        end
    end

    task chk(input [31:0] seen, input [31:0] e);
        begin
            samples_checked++;
            if (seen !== e) begin
                miscompares++;
                $display("MISMATCH %0t seen %h expected %h", $time, seen, e);
            end
        end
    endtask

    // results as they appear against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite)
            chk({pslverr, prdata[30:0]}, expq.pop_front());
        if (look_go)
            chk(look_sel == 2'h2 ? {25'h0, dac_code[6:0]} :
                look_sel == 2'h1 ? {31'h0, irq_n} : {28'h0, tx_line_oe},
                expq.pop_front());
    end

    task apb(input w, input [31:0] a, input [7:0] d);
        begin
            @(posedge pclk);
            psel <= 1'h1;
            pwrite <= w;
            paddr <= a;
            pwdata <= {24'h0, d};
            @(posedge pclk);
            penable <= 1'h1;
            @(posedge pclk);
            while (!pready)
                @(posedge pclk);
            psel <= 1'h0;
            penable <= 1'h0;
        end
    endtask

    function [31:0] ad(input [1:0] ln, input [7:0] i);
        ad = {20'h0, ln, i, 2'h0};
    endfunction

    task wr(input [1:0] ln, input [7:0] i, input [7:0] d);
        apb(1'h1, ad(ln, i), d);
    endtask

    task rd(input [31:0] a, input [31:0] e);
        begin
            expq.push_back(e);
            apb(1'h0, a, 8'h0);
        end
    endtask

    // settle, then sample the enables, the interrupt pin or the link 0 dac code
    task look(input [1:0] q, input [31:0] e);
        begin
            repeat (6) @(posedge pclk);
            expq.push_back(e);
            look_sel <= q;
            look_go <= 1'h1;
            @(posedge pclk);
            look_go <= 1'h0;
        end
    endtask

    task ovc(input [3:0] v);
        begin
            driver_overcurrent <= v;
            repeat (4) @(posedge pclk);
        end
    endtask

    task results;
        begin
            $display("checks %0d mismatches %0d", samples_checked, miscompares);
            if (miscompares == 0 && samples_checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        results;
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        look(1'h0, 32'h0);
        for (l = 0; l < 4; l++)
            rd(ad(l, 8'h23), 32'h17);
        for (k = 0; k < 3; k++) begin
            wr(0, 8'h23, tpl[k]);
            rd(ad(0, 8'h24), scl[k]);
        end
        rd(ad(0, 8'h40), 32'h80000000);
        rd(32'h8E, 32'h80000000);
        rd(32'h108C, 32'h80000000);
        k = $random(seed) & 32'h7F;
        wr(1, 8'h26, k[7:0]);
        wr(1, 8'h25, 8'h9F);
        wr(1, 8'h26, 8'h00);
        wr(1, 8'h25, 8'hDF);
        rd(ad(1, 8'h26), k);
        rd(ad(1, 8'h25), 32'h1F);
        $display("test registers done");
        for (l = 0; l < 4; l++)
            wr(l, 8'h23, 8'h27);
        look(1'h0, 32'hF);
        wr(2, 8'h23, 8'h37);
        look(1'h0, 32'hB);
        wr(2, 8'h23, 8'h27);
        global_tristate_pin <= 1'h1;
        look(1'h0, 32'h0);
        global_tristate_pin <= 1'h0;
        look(1'h0, 32'hF);
        osc_run <= 1'h0;
        repeat (300) @(posedge pclk);
        look(1'h0, 32'h0);
        osc_run <= 1'h1;
        for (k = 1; k < 7; k += 5) begin
            hi <= k;
            repeat (40) @(posedge pclk);
            look(1'h0, 32'h0);
        end
        hi <= 4;
        repeat (40) @(posedge pclk);
        look(1'h0, 32'hF);
        $display("test tristate pins done");
        bp_run <= 4'hD;
        repeat (40) @(posedge pclk);
        look(1'h0, 32'hD);
        wr(1, 8'h70, 8'h04);
        look(1'h0, 32'hF);
        wr(1, 8'h70, 8'h00);
        look(1'h0, 32'hD);
        bp_run <= 4'hF;
        rclk_lost <= 4'h8;
        look(1'h0, 32'hF);
        wr(3, 8'h70, 8'h03);
        look(1'h0, 32'h7);
        rclk_lost <= 4'h0;
        look(1'h0, 32'hF);
        wr(3, 8'h70, 8'h00);
        wr(0, 8'h70, 8'h08);
        look(1'h0, 32'hE);
        wr(0, 8'h70, 8'h00);
        look(1'h0, 32'hF);
        $display("test clock loss done");
        wr(0, 8'h33, 8'h00);
        ovc(4'h1);
        look(1'h1, 32'h1);
        wr(0, 8'h33, 8'h01);
        look(1'h1, 32'h0);
        rd(ad(0, 8'h36), 32'h1);
        rd(ad(0, 8'h3A), 32'h1);
        look(1'h1, 32'h1);
        ovc(4'h0);
        rd(ad(0, 8'h3A), 32'h0);
        wr(0, 8'h35, 8'h01);
        ovc(4'h1);
        rd(ad(0, 8'h3A), 32'h1);
        ovc(4'h0);
        rd(ad(0, 8'h3A), 32'h1);
        $display("test driver fail done");
        rd(ad(0, 8'h3B), 32'h0);
        wr(0, 8'h34, 8'h00);
        // load every link 0 sample with one large positive value
        k = $random(seed);
        wr(0, 8'h26, {3'h1, k[4:0]});
        for (l = 0; l < 64; l++)
            wr(0, 8'h25, 8'h80 | l[7:0]);
        wr(0, 8'h25, 8'hFF);
        rd(ad(0, 8'h26), {27'h1, k[4:0]});
        wr(0, 8'h23, 8'h2B);
        force0 <= 1'h1;
        repeat (400) @(posedge pclk);
        look(2'h2, 32'h3F);
        force0 <= 1'h0;
        repeat (300) @(posedge pclk);
        look(1'h1, 32'h1);
        wr(0, 8'h34, 8'h01);
        look(1'h1, 32'h0);
        wr(0, 8'h3B, 8'h00);
        rd(ad(0, 8'h3B), 32'h1);
        rd(ad(0, 8'h3B), 32'h0);
        look(1'h1, 32'h1);
        $display("test overflow done");
        results;
    end
endmodule // tpsd_top_tb
